// ==== rtl/ppa_regs.svh ====
// Register offsets, field positions and reset values of the port pin block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef PPA_REGS_SVH
`define PPA_REGS_SVH

// Register offsets on the plain register port.
`define PPA_OFS_LOC 8'h00
`define PPA_OFS_SOUT 8'h04
`define PPA_OFS_XFER 8'h08
`define PPA_OFS_PEN 8'h0C
`define PPA_OFS_CTRL 8'h10

// Implemented width of the location and pin enable registers.
`define PPA_HALF_W 16
`define PPA_PINS 16

// Field positions in the location register.
`define PPA_UPPER_SEL_BIT 15
`define PPA_LOWER_SEL_BIT 14
`define PPA_LATCH_HIGH_PIN 1
`define PPA_LATCH_LOW_PIN 0

// Field positions in the control register.
`define PPA_AMUX_LSB 0
`define PPA_AMUX_MSB 1
`define PPA_MODE16_BIT 2
`define PPA_SFF_LSB 6
`define PPA_SFF_MSB 7
`define PPA_CTRL_MASK 32'h0000_00C7

// Select function field codes.
`define PPA_SFF_BOTH 2'h2
`define PPA_SFF_UPPER 2'h1
`define PPA_SFF_NONE 2'h0

// Address multiplex code meaning separate address and data pins.
`define PPA_AMUX_SEPARATE 2'h0

// Reset values.
`define PPA_RST_HALF 16'h0000
`define PPA_RST_WORD 32'h0000_0000
`define PPA_RST_CTRL 8'h00

`endif

// ==== rtl/ppa_pkg.sv ====
// Types shared by the port pin block and its submodules.
// Assumes nothing beyond a SystemVerilog compiler.
package ppa_pkg;

   // One register port request, sampled on the rising clock edge.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } ppa_bus_req_s;

   // One word captured from the external data pins.
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } ppa_capture_s;

   // Pin side view: level driven and whether the port owns the pin.
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] port_owned;
   } ppa_pins_s;

   // Settings of the control register.
   typedef struct packed {
      logic [1:0] select_function_field;
      logic mode16;
      logic [1:0] addr_mux;
   } ppa_ctrl_s;

   // Use of one of the two top pins.
   typedef enum logic [1:0] {
      PPA_TOP_ADDRESS = 2'h1,
      PPA_TOP_SELECT = 2'h2
   } ppa_top_use_e;

endpackage

// ==== rtl/ppa_pin_map.sv ====
// Combinational map from register contents to pin levels and ownership.
// Assumes the caller registers the result before it leaves the chip.
`timescale 1ns/1ps
`include "ppa_regs.svh"

module ppa_pin_map (
   input wire logic [15:0] location_i, // Outgoing location register.
   input wire logic [15:0] enable_i, // Pin function enable register.
   input wire ppa_pkg::ppa_ctrl_s ctrl_i, // Control settings.
   input wire logic xfer_active_i, // A read or write is running.
   input wire logic latch_strobe_low_i, // Low address latch strobe.
   input wire logic latch_strobe_high_i, // High address latch strobe.
   output ppa_pkg::ppa_pins_s pins_o // Next pin levels and owners.
);
   import ppa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Decodes the use of the upper or lower top pin from the select field.
   function automatic ppa_top_use_e top_use(input logic [1:0] sff,
                                            input logic upper);
      ppa_top_use_e use_code;
      use_code = PPA_TOP_ADDRESS;
      if (sff == `PPA_SFF_BOTH) begin
         use_code = PPA_TOP_SELECT;
      end else if (sff == `PPA_SFF_UPPER && upper) begin
         use_code = PPA_TOP_SELECT;
      end
      return use_code;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Builds each pin level; a select only asserts during a transfer.
   always_comb begin
      pins_o.level = location_i;
      if (top_use(ctrl_i.select_function_field, 1'b1) == PPA_TOP_SELECT)
      begin
         pins_o.level[`PPA_UPPER_SEL_BIT] =
            location_i[`PPA_UPPER_SEL_BIT] & xfer_active_i;
      end
      if (top_use(ctrl_i.select_function_field, 1'b0) == PPA_TOP_SELECT)
      begin
         pins_o.level[`PPA_LOWER_SEL_BIT] =
            location_i[`PPA_LOWER_SEL_BIT] & xfer_active_i;
      end
      if (ctrl_i.addr_mux != `PPA_AMUX_SEPARATE) begin
         pins_o.level[`PPA_LATCH_HIGH_PIN] = latch_strobe_high_i;
         pins_o.level[`PPA_LATCH_LOW_PIN] = latch_strobe_low_i;
      end
      pins_o.port_owned = enable_i;
   end

endmodule

// ==== rtl/ppa_read_mux.sv ====
// Read data selection for the register port.
// Assumes the caller registers the selected word for the next cycle.
`timescale 1ns/1ps
`include "ppa_regs.svh"

module ppa_read_mux (
   input wire logic [7:0] addr_i, // Read address.
   input wire logic [15:0] location_i, // Location register.
   input wire logic [31:0] slave_output_word_i, // Slave output word.
   input wire logic [31:0] transfer_word_i, // Transfer word.
   input wire logic [15:0] enable_i, // Pin function enable register.
   input wire ppa_pkg::ppa_ctrl_s ctrl_i, // Control settings.
   output logic [31:0] rdata_o // Selected word, zero if unmapped.
);
   import ppa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Places control fields at their bit positions.
   function automatic logic [31:0] pack_ctrl(input ppa_ctrl_s c);
      logic [31:0] w;
      w = `PPA_RST_WORD;
      w[`PPA_SFF_MSB:`PPA_SFF_LSB] = c.select_function_field;
      w[`PPA_MODE16_BIT] = c.mode16;
      w[`PPA_AMUX_MSB:`PPA_AMUX_LSB] = c.addr_mux;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address decode; upper halves of the short registers read zero.
   always_comb begin
      rdata_o = `PPA_RST_WORD;
      if (addr_i == `PPA_OFS_LOC) begin
         rdata_o = {{`PPA_HALF_W{1'b0}}, location_i};
      end else if (addr_i == `PPA_OFS_SOUT) begin
         rdata_o = slave_output_word_i;
      end else if (addr_i == `PPA_OFS_XFER) begin
         rdata_o = transfer_word_i;
      end else if (addr_i == `PPA_OFS_PEN) begin
         rdata_o = {{`PPA_HALF_W{1'b0}}, enable_i};
      end else if (addr_i == `PPA_OFS_CTRL) begin
         rdata_o = pack_ctrl(ctrl_i);
      end
   end

endmodule

// ==== rtl/ppa_top.sv ====
// Register and pin function slice of a configurable parallel port.
// Assumes a one-cycle register port master and an external transfer
// sequencer that reports activity, latch strobes and captured data.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ppa_regs.svh"

module ppa_top (
   input wire logic clk_i, // Peripheral clock, 10 MHz.
   input wire logic nrst_i, // Synchronous reset, active low.
   input wire logic [7:0] addr_i, // Register byte address.
   input wire logic [31:0] wdata_i, // Register write data.
   input wire logic wr_i, // Write strobe, one cycle.
   input wire logic rd_i, // Read strobe, one cycle.
   output logic [31:0] rdata_o, // Read data, cycle after strobe.
   input wire logic xfer_active_i, // External transfer running.
   input wire logic latch_strobe_low_i, // Low address latch strobe.
   input wire logic latch_strobe_high_i, // High address latch strobe.
   input wire ppa_pkg::ppa_capture_s capture_i, // Word read from pins.
   output logic [15:0] external_location_lines_o, // Pin levels.
   output logic [15:0] pin_function_enable_o, // Port owns the pin.
   output logic [31:0] slave_output_word_o, // Bytes for slave reads.
   output logic [31:0] transfer_word_o, // Master write data.
   output logic [1:0] select_function_field_o, // Select use of top pins.
   output logic mode16_o, // Sixteen-bit transfers.
   output logic [1:0] addr_mux_o // Address multiplex mode.
);
   import ppa_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [15:0] location;
   logic [31:0] slave_output_word;
   logic [31:0] transfer_word;
   logic [15:0] pin_enable;
   ppa_ctrl_s ctrl;

   // Next values and helper nets.
   ppa_bus_req_s req;
   ppa_pins_s next_pins;
   logic [31:0] next_rdata;
   logic [31:0] next_transfer_word;

   ////////////////////////////////////////////////////////////////////////
   // Bundles the register port into one request.
   assign req.wr = wr_i;
   assign req.rd = rd_i;
   assign req.addr = addr_i;
   assign req.wdata = wdata_i;

   ////////////////////////////////////////////////////////////////////////
   // Tells whether a write hits the given offset.
   function automatic logic hit(input ppa_bus_req_s r,
                                input logic [7:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Merges captured pin data into the transfer word by transfer width.
   function automatic logic [31:0] merge_capture(input logic [31:0] old,
                                                 input logic [31:0] cap,
                                                 input logic wide);
      logic [31:0] w;
      w = old;
      if (wide) begin
         w[15:0] = cap[15:0];
      end else begin
         w[7:0] = cap[7:0];
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Location register; only the low half exists, upper bits dropped.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         location <= `PPA_RST_HALF;
      end else if (hit(req, `PPA_OFS_LOC)) begin
         location <= req.wdata[`PPA_HALF_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slave output word, full width read/write.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         slave_output_word <= `PPA_RST_WORD;
      end else if (hit(req, `PPA_OFS_SOUT)) begin
         slave_output_word <= req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer word: a capture from the pins wins over a software write
   // in the same cycle, so read data is never lost.
   always_comb begin
      next_transfer_word = transfer_word;
      if (hit(req, `PPA_OFS_XFER)) begin
         next_transfer_word = req.wdata;
      end
      if (capture_i.valid) begin
         next_transfer_word = merge_capture(transfer_word, capture_i.data,
                                            ctrl.mode16);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         transfer_word <= `PPA_RST_WORD;
      end else begin
         transfer_word <= next_transfer_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin function enables; only the low half exists.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pin_enable <= `PPA_RST_HALF;
      end else if (hit(req, `PPA_OFS_PEN)) begin
         pin_enable <= req.wdata[`PPA_PINS-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register holding select field, width and multiplex mode.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ctrl <= ppa_ctrl_s'(5'(`PPA_RST_CTRL));
      end else if (hit(req, `PPA_OFS_CTRL)) begin
         ctrl.select_function_field <=
            req.wdata[`PPA_SFF_MSB:`PPA_SFF_LSB];
         ctrl.mode16 <= req.wdata[`PPA_MODE16_BIT];
         ctrl.addr_mux <= req.wdata[`PPA_AMUX_MSB:`PPA_AMUX_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Works out the next pin levels from the current registers.
   ppa_pin_map u_pin_map (
      .location_i(location),
      .enable_i(pin_enable),
      .ctrl_i(ctrl),
      .xfer_active_i(xfer_active_i),
      .latch_strobe_low_i(latch_strobe_low_i),
      .latch_strobe_high_i(latch_strobe_high_i),
      .pins_o(next_pins)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs: a write seen at edge N reaches the pins at edge N+1.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         external_location_lines_o <= `PPA_RST_HALF;
         pin_function_enable_o <= `PPA_RST_HALF;
      end else begin
         external_location_lines_o <= next_pins.level;
         pin_function_enable_o <= next_pins.port_owned;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data words and settings handed on to the transfer sequencer.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         slave_output_word_o <= `PPA_RST_WORD;
         transfer_word_o <= `PPA_RST_WORD;
         select_function_field_o <= `PPA_SFF_NONE;
         mode16_o <= 1'b0;
         addr_mux_o <= `PPA_AMUX_SEPARATE;
      end else begin
         slave_output_word_o <= slave_output_word;
         transfer_word_o <= transfer_word;
         select_function_field_o <= ctrl.select_function_field;
         mode16_o <= ctrl.mode16;
         addr_mux_o <= ctrl.addr_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path: word selected in the strobe cycle, shown the cycle after.
   ppa_read_mux u_read_mux (
      .addr_i(req.addr),
      .location_i(location),
      .slave_output_word_i(slave_output_word),
      .transfer_word_i(transfer_word),
      .enable_i(pin_enable),
      .ctrl_i(ctrl),
      .rdata_o(next_rdata)
   );

   // Read data stand only in the cycle after the strobe, else zero.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= `PPA_RST_WORD;
      end else if (req.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= `PPA_RST_WORD;
      end
   end

endmodule

// ==== test/ppa_ext_dev.sv ====
// Model of the external transfer sequencer and the device on the pins.
// Assumes start_i is a one-cycle pulse given only while the model idles.
`timescale 1ns/1ps
module ppa_ext_dev (
   input wire logic clk_i, // Clock.
   input wire logic start_i, // Begin one transfer.
   input wire logic [7:0] wait_i, // Data phase length.
   input wire logic [31:0] data_i, // Word the device returns.
   output logic xfer_o, // Transfer running.
   output logic ll_o, // Low latch strobe.
   output logic lh_o, // High latch strobe.
   output ppa_pkg::ppa_capture_s cap_o // Word captured from pins.
);
   import ppa_pkg::*;
   int cnt;
   logic [31:0] last;
   // Idle state at time zero.
   initial begin
      cnt = 0;
      last = 32'h0000_0000;
      {xfer_o, ll_o, lh_o} = 3'h0;
      cap_o = '0;
   end
   // Latch high then low half, hold the data phase, return one word.
   always @(posedge clk_i) begin
      lh_o <= start_i;
      ll_o <= cnt == int'(wait_i) + 2;
      xfer_o <= start_i || cnt > 1;
      cap_o.valid <= cnt == 1;
      cap_o.data <= (cnt == 1) ? data_i : ~last; // Released bus never stale.
      last <= (cnt == 1) ? data_i : last;
      cnt <= start_i ? int'(wait_i) + 2 : (cnt > 0 ? cnt - 1 : 0);
   end
endmodule

// ==== test/ppa_top_properties.sv ====
// Concurrent checks on the ports of the port pin block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ppa_top_properties (
   input wire logic clk_i, // Clock.
   input wire logic nrst_i, // Reset.
   input wire logic [7:0] addr_i, // Address.
   input wire logic [31:0] wdata_i, // Write data.
   input wire logic wr_i, // Write strobe.
   input wire logic rd_i, // Read strobe.
   input wire logic [31:0] rdata_o, // Read data.
   input wire logic xfer_active_i, // Transfer on.
   input wire logic latch_strobe_low_i, // Low latch.
   input wire logic latch_strobe_high_i, // High latch.
   input wire ppa_pkg::ppa_capture_s capture_i, // Captured word.
   input wire logic [15:0] external_location_lines_o, // Pins.
   input wire logic [15:0] pin_function_enable_o, // Owners.
   input wire logic [31:0] slave_output_word_o, // Slave word.
   input wire logic [31:0] transfer_word_o, // Transfer word.
   input wire logic [1:0] select_function_field_o, // Select use.
   input wire logic [1:0] addr_mux_o // Multiplex mode.
);
   import ppa_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   //////////////////////////////////////////////////////////////////
   // Register port answers and register copies on the outputs.
   property p_rd_idle;
      !rd_i |=> rdata_o == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");
   property p_loc_rb;
      wr_i && addr_i == 8'h00 ##1 !wr_i ##1 rd_i && addr_i == 8'h00 |=>
         rdata_o == {16'h0000, $past(wdata_i[15:0], 3)};
   endproperty
   a_loc_rb: assert property (p_loc_rb)
      else $error("location readback wrong");
   property p_pen;
      wr_i && addr_i == 8'h0C |-> ##2
         pin_function_enable_o == $past(wdata_i[15:0], 2);
   endproperty
   a_pen: assert property (p_pen)
      else $error("pin owners do not follow write");
   property p_sout;
      wr_i && addr_i == 8'h04 |-> ##2 slave_output_word_o == $past(wdata_i, 2);
   endproperty
   a_sout: assert property (p_sout)
      else $error("slave word does not follow write");
   property p_xfer;
      wr_i && addr_i == 8'h08 && !capture_i.valid ##1 !capture_i.valid |=>
         transfer_word_o == $past(wdata_i, 2);
   endproperty
   a_xfer: assert property (p_xfer)
      else $error("transfer word does not follow write");
   property p_ctrl;
      wr_i && addr_i == 8'h10 |-> ##2
         {select_function_field_o, addr_mux_o} ==
         {$past(wdata_i[7:6], 2), $past(wdata_i[1:0], 2)};
   endproperty
   a_ctrl: assert property (p_ctrl)
      else $error("control copy does not follow write");
   property p_reset;
      disable iff (1'b0) !nrst_i |=> rdata_o == 32'h0 &&
         {external_location_lines_o, pin_function_enable_o} == 32'h0 &&
         slave_output_word_o == 32'h0 && transfer_word_o == 32'h0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not zero in reset");
   // Select pins idle and latch strobes routed to the two lowest pins.
   property p_cs_idle;
      !xfer_active_i ##1 select_function_field_o inside {2'h1, 2'h2} |->
         !external_location_lines_o[15] && (select_function_field_o == 2'h1
         || !external_location_lines_o[14]);
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("select pin active outside a transfer");
   property p_latch;
      addr_mux_o != 2'h0 |-> external_location_lines_o[1:0] ==
         $past({latch_strobe_high_i, latch_strobe_low_i});
   endproperty
   a_latch: assert property (p_latch)
      else $error("latch strobes not on lowest pins");
   c_capture: cover property (capture_i.valid);
   c_cs_on: cover property (xfer_active_i && select_function_field_o == 2'h2);
   c_latch: cover property (addr_mux_o != 2'h0 && latch_strobe_high_i);
endmodule
bind ppa_top ppa_top_properties ppa_top_properties_inst (.clk_i, .nrst_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .xfer_active_i,
   .latch_strobe_low_i, .latch_strobe_high_i, .capture_i,
   .external_location_lines_o, .pin_function_enable_o, .slave_output_word_o,
   .transfer_word_o, .select_function_field_o, .addr_mux_o);

// ==== test/testbench.sv ====
// Self-checking bench for the port pin block with a bench-side model.
// Assumes the external device model and the property checker exist.
`timescale 1ns/1ps
module testbench;
   import ppa_pkg::*;
   logic clk_i, nrst_i, wr_i, rd_i, xfer, ll, lh, start, m16;
   logic [7:0] addr_i, wait_v, m_ctrl;
   logic [31:0] wdata_i, rdata_o, sout, xw, dev_data, m_sout, m_xfer;
   logic [15:0] pins, pen, m_loc, m_pen;
   logic [1:0] sff, amux;
   ppa_capture_s cap;
   int error_cnt, n_compared, seed;
   logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   ppa_top ppa_top_inst (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .xfer_active_i(xfer), .latch_strobe_low_i(ll),
      .latch_strobe_high_i(lh), .capture_i(cap),
      .external_location_lines_o(pins), .pin_function_enable_o(pen),
      .slave_output_word_o(sout), .transfer_word_o(xw),
      .select_function_field_o(sff), .mode16_o(m16), .addr_mux_o(amux));
   ppa_ext_dev ppa_ext_dev_inst (.clk_i, .start_i(start), .wait_i(wait_v),
      .data_i(dev_data), .xfer_o(xfer), .ll_o(ll), .lh_o(lh), .cap_o(cap));
   //////////////////////////////////////////////////////////////////
   // Comparison, bus tasks and the bench model of the registers.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00: return {16'h0000, m_loc};
         8'h04: return m_sout;
         8'h08: return m_xfer;
         8'h0C: return {16'h0000, m_pen};
         8'h10: return {24'h000000, m_ctrl};
         default: return 32'h0000_0000;
      endcase
   endfunction
   function automatic logic [15:0] exp_pins(input logic x);
      logic [15:0] p;
      p = m_loc;
      if (m_ctrl[7:6] == 2'h2) p[14] = m_loc[14] & x;
      if (m_ctrl[7:6] == 2'h1 || m_ctrl[7:6] == 2'h2) p[15] = m_loc[15] & x;
      if (m_ctrl[1:0] != 2'h0) p[1:0] = 2'h0; // Strobes are idle here.
      return p;
   endfunction
   task automatic mwr(input logic [7:0] a, input logic [31:0] d);
      if (a == 8'h00 || a == 8'h0C) d[31:16] = 16'h0000;
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      case (a)
         8'h00: m_loc = d[15:0];
         8'h04: m_sout = d;
         8'h08: m_xfer = d;
         8'h0C: m_pen = d[15:0];
         8'h10: m_ctrl = d[7:0] & 8'hC7;
         default: ;
      endcase
   endtask
   task automatic rdc(input logic [7:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, exp_rd(a));
   endtask
   task automatic outs();
      repeat (2) @(posedge clk_i);
      #1 chk(32'(pins), 32'(exp_pins(1'b0)));
      chk(32'(pen), 32'(m_pen));
      chk(sout, m_sout);
      chk(xw, m_xfer);
      chk({27'h0, sff, m16, amux}, {27'h0, m_ctrl[7:6], m_ctrl[2:0]});
   endtask
   task automatic zero_chk();
      {m_loc, m_pen, m_sout, m_xfer, m_ctrl} = '0;
      outs();
      foreach (ofs[i]) rdc(ofs[i]);
   endtask
   // One device transfer; the model takes the captured byte or half word.
   task automatic run(input logic mid);
      int n;
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      if (mid) begin
         repeat (4) @(posedge clk_i);
         #1 chk(32'(pins), 32'(exp_pins(1'b1)));
      end
      n = 0;
      while (cap.valid !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         #1 n++;
      end
      if (n == 100) chk(32'h1, 32'h0);
      if (m_ctrl[2]) m_xfer[15:0] = dev_data[15:0];
      else m_xfer[7:0] = dev_data[7:0];
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////
   // Clock, watchdog and the test sequence.
   always #50 clk_i = ~clk_i;
   initial begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      {clk_i, nrst_i, wr_i, rd_i, start} = 5'h00;
      {addr_i, wait_v, wdata_i, dev_data} = '0;
      {error_cnt, n_compared} = '0;
      seed = 77881;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      zero_chk();
      $display("test reset done");
      foreach (ofs[i]) mwr(ofs[i], $random(seed));
      foreach (ofs[i]) rdc(ofs[i]);
      outs();
      $display("test registers done");
      wait_v <= 8'd20;
      for (int c = 0; c < 16; c++) begin
         mwr(8'h10, {24'h0, 2'(c >> 2), 6'(c & 1)});
         mwr(8'h00, $random(seed));
         rdc(8'h00);
         mwr(8'h0C, $random(seed));
         if (c[1]) run(1'b1);
         outs();
      end
      $display("test pins done");
      for (int w = 0; w < 4; w++) begin
         mwr(8'h10, 32'(w[0]) << 2);
         mwr(8'h08, $random(seed));
         dev_data <= $random(seed);
         wait_v <= 8'(w * 3);
         run(1'b0);
         outs();
         rdc(8'h08);
      end
      $display("test capture done");
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      zero_chk();
      $display("test second reset done");
      report_and_stop();
   end
endmodule
